// [sim/ftc_host.sv]
// Host microprocessor model issuing register writes and reads.
`timescale 1ns/1ps
module ftc_host (
  input wire logic CLK,
  output ftc_pkg::ftc_host_req_t HOST_REQ,
  input wire logic [7:0] HOST_RDATA,
  input wire logic HOST_RVALID
);
  import ftc_pkg::*;
  initial begin
    HOST_REQ = '0;
  end
  // ==========================================================================
  // Bus cycles
  // Fixed bits are forced here, so no caller can upset the driver settings.
  task automatic write(input logic [5:0] addr, input logic [7:0] data);
    logic [7:0] d;
    d = data;
    if (addr == 6'h11) begin
      d = {1'b0, d[6:5], 1'b1, d[3:0]};
    end
    if (addr == 6'h12) begin
      d = {2'h0, d[5:0]};
    end
    @(negedge CLK);
    HOST_REQ <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: d};
    @(negedge CLK);
    HOST_REQ <= '0;
  endtask : write

  task automatic read(input logic [5:0] addr, output logic [7:0] data, output logic ok);
    ok = 1'b0;
    data = 8'hXX;
    @(negedge CLK);
    HOST_REQ <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
    @(negedge CLK);
    HOST_REQ <= '0;
    for (int i = 0; i < 4 && !ok; i++) begin
      if (HOST_RVALID === 1'b1) begin
        ok = 1'b1;
        data = HOST_RDATA;
      end else begin
        @(negedge CLK);
      end
    end
  endtask : read
endmodule : ftc_host

// [sim/testbench.sv]
// Self-checking testbench of the frame and transmitter register block.
`timescale 1ns/1ps
module testbench;
  import ftc_pkg::*;
  logic CLK, RESET_N, CRC_LOAD, RX_START, RX_BIT_VALID, RX_BIT, RX_DONE, TX_DONE;
  logic ENCODER_BIT, EXTERNAL_MODULATION_INPUT, CARRIER_IN, HOST_RVALID, FIFO_WVALID;
  logic [15:0] CRC_RESULT;
  logic [7:0] HOST_RDATA, FIFO_WDATA, sel;
  logic [5:0] DRIVER_CONDUCTANCE_SETTING;
  logic [3:0] TX_LAST_BYTE_BITS;
  ftc_host_req_t HOST_REQ;
  ftc_ant_t ANTENNA;
  int errors = 0;
  int num_checks = 0;
  // Antenna cases: control byte, carrier level, expected antenna one, antenna two.
  localparam logic [10:0] ACASE [7] = '{{8'h53, 3'b111}, {8'h50, 3'b100},
    {8'h16, 3'b101}, {8'h12, 3'b100}, {8'h1E, 3'b001}, {8'h1E, 3'b100}, {8'h33, 3'b111}};
  ftc_regs i_dut (.CLK(CLK), .RESET_N(RESET_N), .HOST_REQ(HOST_REQ), .HOST_RDATA(HOST_RDATA),
    .HOST_RVALID(HOST_RVALID), .CRC_RESULT(CRC_RESULT), .CRC_LOAD(CRC_LOAD),
    .RX_START(RX_START), .RX_BIT_VALID(RX_BIT_VALID), .RX_BIT(RX_BIT), .RX_DONE(RX_DONE),
    .TX_DONE(TX_DONE), .ENCODER_BIT(ENCODER_BIT),
    .EXTERNAL_MODULATION_INPUT(EXTERNAL_MODULATION_INPUT), .CARRIER_IN(CARRIER_IN),
    .ANTENNA(ANTENNA), .DRIVER_CONDUCTANCE_SETTING(DRIVER_CONDUCTANCE_SETTING),
    .TX_LAST_BYTE_BITS(TX_LAST_BYTE_BITS), .FIFO_WDATA(FIFO_WDATA), .FIFO_WVALID(FIFO_WVALID));
  ftc_host i_host (.CLK(CLK), .HOST_REQ(HOST_REQ), .HOST_RDATA(HOST_RDATA),
    .HOST_RVALID(HOST_RVALID));
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  // ==========================================================================
  // Checking helpers
  task automatic test_done();
    if (errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic rd(input logic [5:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    i_host.read(addr, d, ok);
    if (ok !== 1'b1) begin
      errors++;
      test_done();
    end else begin
      chk($sformatf("reg %h", addr), exp, d);
    end
  endtask : rd

  // A bounded wait, since a missing push would otherwise hang the run.
  task automatic fifo_wait(input logic [7:0] exp);
    for (int i = 0; i < 6; i++) begin
      if (FIFO_WVALID === 1'b1) begin
        chk("fifo byte", exp, FIFO_WDATA);
        return;
      end
      @(negedge CLK);
    end
    errors++;
    test_done();
  endtask : fifo_wait

  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge CLK);
    s = 1'b0;
  endtask : pulse
  // ==========================================================================
  // Main sequence
  initial begin
    {RESET_N, CRC_LOAD, RX_START, RX_BIT_VALID, RX_BIT, RX_DONE, TX_DONE} = '0;
    {ENCODER_BIT, EXTERNAL_MODULATION_INPUT, CARRIER_IN} = '0;
    CRC_RESULT = 16'h0000;
    repeat (6) @(negedge CLK);
    RESET_N = 1'b1;
    rd(6'h0F, 8'h00);
    rd(6'h11, 8'h58);
    rd(6'h12, 8'h3F);
    rd(6'h20, 8'h00);
    chk("conductance out", 8'h3F, {2'h0, DRIVER_CONDUCTANCE_SETTING});
    chk("last bits", 8'h08, {4'h0, TX_LAST_BYTE_BITS});
    CRC_RESULT = 16'hA55A;
    pulse(CRC_LOAD);
    rd(6'h0D, 8'h5A);
    rd(6'h0E, 8'hA5);
    i_host.write(6'h0D, 8'hFF);
    i_host.write(6'h0E, 8'h00);
    rd(6'h0D, 8'h5A);
    rd(6'h0E, 8'hA5);
    i_host.write(6'h12, 8'h15);
    rd(6'h12, 8'h15);
    chk("conductance out", 8'h15, {2'h0, DRIVER_CONDUCTANCE_SETTING});
    i_host.write(6'h0F, 8'h75);
    chk("last bits", 8'h05, {4'h0, TX_LAST_BYTE_BITS});
    pulse(TX_DONE);
    rd(6'h0F, 8'h70);
    chk("last bits", 8'h08, {4'h0, TX_LAST_BYTE_BITS});
    pulse(RX_START);
    RX_BIT = 1'b1;
    pulse(RX_BIT_VALID);
    fifo_wait(8'h80);
    @(negedge CLK);
    pulse(RX_BIT_VALID);
    pulse(RX_DONE);
    fifo_wait(8'h01);
    rd(6'h0F, 8'h00);
    for (int i = 0; i < 8; i++) begin
      ENCODER_BIT = i[2];
      EXTERNAL_MODULATION_INPUT = ~i[2];
      i_host.write(6'h11, {1'b0, i[1:0], 5'h10});
      repeat (6) @(negedge CLK);
      sel = (i[1:0] == 2'h0) ? 8'h00 : (i[1:0] == 2'h1) ? 8'h01 : {7'h00, i[0] ^ i[2]};
      chk("modulator input", sel, {7'h00, ANTENNA.modulator_input});
    end
    foreach (ACASE[k]) begin
      CARRIER_IN = ACASE[k][2];
      i_host.write(6'h11, ACASE[k][10:3]);
      repeat (6) @(negedge CLK);
      chk("antenna one", {7'h00, ACASE[k][1]}, {7'h00, ANTENNA.antenna_output_one});
      chk("antenna two", {7'h00, ACASE[k][0]}, {7'h00, ANTENNA.antenna_output_two});
    end
    test_done();
  end
endmodule : testbench

// [verilog/ftc_defines.svh]
// Register offsets, field positions and reset values of the frame and transmitter registers.
`ifndef FTC_DEFINES_SVH
`define FTC_DEFINES_SVH
// ==========================================================================
// Register offsets
`define FTC_ADDR_W 6
`define FTC_OFF_CRC_LOW 6'h0D
`define FTC_OFF_CRC_HIGH 6'h0E
`define FTC_OFF_FRAME_ADJ 6'h0F
`define FTC_OFF_TX_CTRL 6'h11
`define FTC_OFF_CONDUCT 6'h12
// ==========================================================================
// Reset values
`define FTC_RST_FRAME_ADJ 8'h00
`define FTC_RST_TX_CTRL 8'h58
`define FTC_RST_CONDUCT 8'h3F
`define FTC_RST_CRC 8'h00
`define FTC_RST_BYTE 8'h00
// ==========================================================================
// Field positions
`define FTC_RXOFF_HI 6
`define FTC_RXOFF_LO 4
`define FTC_LAST_HI 2
`define FTC_LAST_LO 0
`define FTC_MODSEL_HI 6
`define FTC_MODSEL_LO 5
`define FTC_ANT2_INV 3
`define FTC_ANT2_CW 2
`define FTC_ANT2_RF 1
`define FTC_ANT1_RF 0
`define FTC_COND_HI 5
`define FTC_COND_LO 0
// ==========================================================================
// Small constants
`define FTC_POS_ZERO 3'h0
`define FTC_POS_LAST 3'h7
`define FTC_ALL_BITS 4'h8
`endif

// [verilog/ftc_pkg.sv]
// Types shared by the frame and transmitter register block.
package ftc_pkg;
  // ========================================================================
  // Modulator source encodings
  typedef enum logic [1:0] {
    FTC_MOD_LOW = 2'h0,
    FTC_MOD_HIGH = 2'h1,
    FTC_MOD_ENCODER = 2'h2,
    FTC_MOD_EXTERNAL = 2'h3
  } ftc_mod_sel_t;

  // ========================================================================
  // Host register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } ftc_host_req_t;

  // ========================================================================
  // Antenna pin group
  typedef struct packed {
    logic antenna_output_one;
    logic antenna_output_two;
    logic modulator_input;
  } ftc_ant_t;

  // ========================================================================
  // Whole block state
  typedef struct packed {
    logic [7:0] crc_low_byte;
    logic [7:0] crc_high_byte;
    logic [7:0] frame_bit_adjust;
    logic [7:0] transmit_pin_control;
    logic [7:0] driver_conductance_reg;
    logic [7:0] rdata;
    logic rvalid;
    logic ext_s1;
    logic ext_s2;
    logic car_s1;
    logic car_s2;
    logic [2:0] rx_pos;
    logic rx_have;
    logic [7:0] rx_acc;
    logic [7:0] fifo_data;
    logic fifo_valid;
    ftc_ant_t ant;
  } ftc_state_t;
endpackage : ftc_pkg

// [verilog/ftc_regs.sv]
// Frame bit adjustment, CRC result and transmitter pin control registers.
`timescale 1ns/1ps
`include "ftc_defines.svh"
// ==========================================================================
// What this block does
// RULE1: CRC low byte readable, valid when done.
// RULE2: CRC high byte readable, undefined for 8-bit.
// RULE3: Receive offset places first bit, then wraps.
// RULE4: Receive offset clears itself after reception.
// RULE5: Last byte bit count, zero sends eight.
// RULE6: Last byte count clears after transmission.
// RULE7: Modulator source low, high, encoder, external.
// RULE8: Invert bit inverts antenna two carrier.
// RULE9: Continuous bit gives unmodulated antenna two carrier.
// RULE10: Antenna two enable: modulated carrier, else fixed.
// RULE11: Antenna one enable: modulated carrier, else fixed.
// RULE12: Six-bit field sets driver conductance.
// RULE13: Host keeps control bit7 zero, bit4 one.
// RULE14: Host keeps conductance bits 7:6 zero.
// RULE15: Host writes to CRC bytes are ignored.
module ftc_regs (
  input wire logic CLK,
  input wire logic RESET_N,
  input ftc_pkg::ftc_host_req_t HOST_REQ,
  output logic [7:0] HOST_RDATA,
  output logic HOST_RVALID,
  input wire logic [15:0] CRC_RESULT,
  input wire logic CRC_LOAD,
  input wire logic RX_START,
  input wire logic RX_BIT_VALID,
  input wire logic RX_BIT,
  input wire logic RX_DONE,
  input wire logic TX_DONE,
  input wire logic ENCODER_BIT,
  input wire logic EXTERNAL_MODULATION_INPUT,
  input wire logic CARRIER_IN,
  output ftc_pkg::ftc_ant_t ANTENNA,
  output logic [5:0] DRIVER_CONDUCTANCE_SETTING,
  output logic [3:0] TX_LAST_BYTE_BITS,
  output logic [7:0] FIFO_WDATA,
  output logic FIFO_WVALID
);
  import ftc_pkg::*;

  // ========================================================================
  // Helpers
  function automatic logic [3:0] bits_to_send(input logic [2:0] cnt);
    bits_to_send = (cnt == `FTC_POS_ZERO) ? `FTC_ALL_BITS : {1'b0, cnt}; // RULE5
  endfunction : bits_to_send

  function automatic logic host_wr_at(input ftc_host_req_t req, input logic [5:0] off);
    host_wr_at = req.wr && (req.addr == off);
  endfunction : host_wr_at

  ftc_state_t st;
  ftc_state_t next_st;
  ftc_mod_sel_t mod_sel;
  logic mod_src;
  logic car2;
  logic [7:0] rx_seen;

  // A byte that has just filled position 7 already sits in the push register, not the assembler.
  assign rx_seen = st.fifo_valid ? st.fifo_data : st.rx_acc;

  assign mod_sel = ftc_mod_sel_t'(st.transmit_pin_control[`FTC_MODSEL_HI:`FTC_MODSEL_LO]);

  // ========================================================================
  // Next state
  always_comb begin
    next_st = st;
    next_st.fifo_valid = 1'b0;
    next_st.rvalid = 1'b0;
    next_st.ext_s1 = EXTERNAL_MODULATION_INPUT;
    next_st.ext_s2 = st.ext_s1;
    next_st.car_s1 = CARRIER_IN;
    next_st.car_s2 = st.car_s1;
    // Only the CRC engine loads the result bytes; host writes never reach them.
    if (CRC_LOAD) begin
      next_st.crc_low_byte = CRC_RESULT[7:0]; // RULE1
      next_st.crc_high_byte = CRC_RESULT[15:8]; // RULE2 RULE15
    end
    // Hardware clears first so that a host write in the same cycle arms the next frame.
    if (RX_DONE) begin
      next_st.frame_bit_adjust[`FTC_RXOFF_HI:`FTC_RXOFF_LO] = `FTC_POS_ZERO; // RULE4
    end
    if (TX_DONE) begin
      next_st.frame_bit_adjust[`FTC_LAST_HI:`FTC_LAST_LO] = `FTC_POS_ZERO; // RULE6
    end
    if (host_wr_at(HOST_REQ, `FTC_OFF_FRAME_ADJ)) begin
      next_st.frame_bit_adjust = HOST_REQ.wdata;
    end
    if (host_wr_at(HOST_REQ, `FTC_OFF_TX_CTRL)) begin
      next_st.transmit_pin_control = HOST_REQ.wdata; // RULE13
    end
    if (host_wr_at(HOST_REQ, `FTC_OFF_CONDUCT)) begin
      next_st.driver_conductance_reg = HOST_REQ.wdata; // RULE14
    end
    if (HOST_REQ.rd) begin
      next_st.rvalid = 1'b1;
      case (HOST_REQ.addr)
        `FTC_OFF_CRC_LOW: next_st.rdata = st.crc_low_byte; // RULE1
        `FTC_OFF_CRC_HIGH: next_st.rdata = st.crc_high_byte; // RULE2
        `FTC_OFF_FRAME_ADJ: next_st.rdata = st.frame_bit_adjust;
        `FTC_OFF_TX_CTRL: next_st.rdata = st.transmit_pin_control;
        `FTC_OFF_CONDUCT: next_st.rdata = st.driver_conductance_reg;
        default: next_st.rdata = `FTC_RST_BYTE;
      endcase
    end
    // Bits below the start offset of the first byte are left at zero.
    if (RX_START) begin
      next_st.rx_pos = st.frame_bit_adjust[`FTC_RXOFF_HI:`FTC_RXOFF_LO]; // RULE3
      next_st.rx_acc = `FTC_RST_BYTE;
      next_st.rx_have = 1'b0;
    end else if (RX_BIT_VALID) begin
      next_st.rx_acc[st.rx_pos] = RX_BIT; // RULE3
      next_st.rx_pos = st.rx_pos + 3'h1;
      next_st.rx_have = 1'b1;
      if (st.rx_pos == `FTC_POS_LAST) begin
        next_st.fifo_data = next_st.rx_acc; // RULE3
        next_st.fifo_valid = 1'b1;
        next_st.rx_acc = `FTC_RST_BYTE;
        next_st.rx_have = 1'b0;
      end
    end else if (RX_DONE && st.rx_have) begin
      next_st.fifo_data = st.rx_acc;
      next_st.fifo_valid = 1'b1;
      next_st.rx_have = 1'b0;
    end
    case (mod_sel)
      FTC_MOD_LOW: mod_src = 1'b0; // RULE7
      FTC_MOD_HIGH: mod_src = 1'b1; // RULE7
      FTC_MOD_ENCODER: mod_src = ENCODER_BIT; // RULE7
      FTC_MOD_EXTERNAL: mod_src = st.ext_s2; // RULE7
      default: mod_src = 1'b0;
    endcase
    next_st.ant.modulator_input = mod_src;
    car2 = st.transmit_pin_control[`FTC_ANT2_INV] ? ~st.car_s2 : st.car_s2; // RULE8
    // A low modulator input blanks antenna one, and antenna two unless the continuous bit is set, giving full-depth keying.
    next_st.ant.antenna_output_one = st.transmit_pin_control[`FTC_ANT1_RF]
      & st.car_s2 & st.ant.modulator_input; // RULE11
    next_st.ant.antenna_output_two = st.transmit_pin_control[`FTC_ANT2_RF]
      & car2 & (st.transmit_pin_control[`FTC_ANT2_CW] | st.ant.modulator_input); // RULE9 RULE10
  end

  // ========================================================================
  // State register
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st <= '0;
      st.frame_bit_adjust <= `FTC_RST_FRAME_ADJ;
      st.transmit_pin_control <= `FTC_RST_TX_CTRL;
      st.driver_conductance_reg <= `FTC_RST_CONDUCT;
      st.crc_low_byte <= `FTC_RST_CRC;
      st.crc_high_byte <= `FTC_RST_CRC;
    end else begin
      st <= next_st;
    end
  end

  assign HOST_RDATA = st.rdata;
  assign HOST_RVALID = st.rvalid;
  assign ANTENNA = st.ant;
  assign DRIVER_CONDUCTANCE_SETTING =
    st.driver_conductance_reg[`FTC_COND_HI:`FTC_COND_LO]; // RULE12
  assign TX_LAST_BYTE_BITS =
    bits_to_send(st.frame_bit_adjust[`FTC_LAST_HI:`FTC_LAST_LO]); // RULE5
  assign FIFO_WDATA = st.fifo_data;
  assign FIFO_WVALID = st.fifo_valid;

  // ========================================================================
  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  sequence s_rx_arm;
    RX_START && !RX_BIT_VALID;
  endsequence
  sequence s_rx_bit;
    RX_BIT_VALID && !RX_START;
  endsequence

  a_crc_low_read: assert property (HOST_REQ.rd && HOST_REQ.addr == `FTC_OFF_CRC_LOW
    |=> HOST_RVALID && HOST_RDATA == $past(st.crc_low_byte)) // RULE1
    else $error("CRC low byte read wrong.");
  a_crc_high_load: assert property (CRC_LOAD |=> st.crc_high_byte == $past(CRC_RESULT[15:8])) // RULE2
    else $error("CRC high byte not loaded.");
  a_rx_first_place: assert property (s_rx_arm ##1 s_rx_bit // RULE3
    |=> rx_seen[$past(st.frame_bit_adjust[`FTC_RXOFF_HI:`FTC_RXOFF_LO], 2)]
    == $past(RX_BIT))
    else $error("First received bit misplaced.");
  a_rx_offset_clear: assert property (RX_DONE && !HOST_REQ.wr
    |=> st.frame_bit_adjust[`FTC_RXOFF_HI:`FTC_RXOFF_LO] == `FTC_POS_ZERO) // RULE4
    else $error("Receive offset not cleared.");
  a_last_bits_map: assert property (st.frame_bit_adjust[`FTC_LAST_HI:`FTC_LAST_LO] == `FTC_POS_ZERO
    |-> TX_LAST_BYTE_BITS == `FTC_ALL_BITS) // RULE5
    else $error("Zero count must send eight bits.");
  a_tx_count_clear: assert property (TX_DONE && !HOST_REQ.wr
    |=> st.frame_bit_adjust[`FTC_LAST_HI:`FTC_LAST_LO] == `FTC_POS_ZERO) // RULE6
    else $error("Last bit count not cleared.");
  a_mod_source: assert property (mod_sel == FTC_MOD_EXTERNAL && !HOST_REQ.wr
    |=> ANTENNA.modulator_input == $past(st.ext_s2)) // RULE7
    else $error("Modulator not following external input.");
  a_ant2_invert: assert property (st.transmit_pin_control[`FTC_ANT2_INV:`FTC_ANT2_RF] == `FTC_POS_LAST
    |=> ANTENNA.antenna_output_two == !$past(st.car_s2)) // RULE8 RULE9
    else $error("Antenna two not inverted continuous carrier.");
  a_ant2_off: assert property (!st.transmit_pin_control[`FTC_ANT2_RF]
    |=> !ANTENNA.antenna_output_two) // RULE10
    else $error("Antenna two not held low.");
  a_ant1_mod: assert property (st.transmit_pin_control[`FTC_ANT1_RF]
    |=> ANTENNA.antenna_output_one == ($past(st.car_s2) && $past(st.ant.modulator_input))) // RULE11
    else $error("Antenna one not modulated carrier.");
  a_conduct_out: assert property (HOST_REQ.wr && HOST_REQ.addr == `FTC_OFF_CONDUCT
    |=> DRIVER_CONDUCTANCE_SETTING == $past(HOST_REQ.wdata[5:0])) // RULE12
    else $error("Conductance setting not updated.");
  a_crc_write_ignored: assert property (HOST_REQ.wr && HOST_REQ.addr == `FTC_OFF_CRC_LOW
    && !CRC_LOAD |=> $stable(st.crc_low_byte)) // RULE15
    else $error("Host write altered CRC byte.");
endmodule : ftc_regs
